// file: design/sas_top.v
// What this block does
// - Clear whole result to zero before trials.
// - Trial bits seven down to zero, set one.
// - Keep bit if comparator high, else clear.
// - After last bit set done, stop.
// - Read returning done clears enable.
// - Done stays set until cleared by read.
// - Enable self-clears at end, no restart.
// - Select defaults 000, temperature sensor.
// - Codes 001..111 pick external inputs 0..6.
// - Result drives DAC, compared every trial.
// - Comparator high when input exceeds DAC.
`timescale 1ns/1ns
`default_nettype none
`include "sas_regs.vh"
module sas_top #(
  parameter TRIAL_CYCLES = `SAS_TRIAL_CYC
) (
  input  wire        CLOCK,
  input  wire        RST_N,
  input  wire [31:0] AWADDR,
  input  wire        AWVALID,
  output reg         AWREADY,
  input  wire [31:0] WDATA,
  input  wire [3:0]  WSTRB,
  input  wire        WVALID,
  output reg         WREADY,
  output reg  [1:0]  BRESP,
  output reg         BVALID,
  input  wire        BREADY,
  input  wire [31:0] ARADDR,
  input  wire        ARVALID,
  output reg         ARREADY,
  output reg  [31:0] RDATA,
  output reg  [1:0]  RRESP,
  output reg         RVALID,
  input  wire        RREADY,
  input  wire        COMP_HIGH,
  output reg  [7:0]  DAC_CODE,
  output reg  [2:0]  INPUT_CHANNEL_SELECT,
  output reg         SENSOR_ENABLE,
  output reg         CONV_BUSY,
  output reg         IRQ
);
  // ----------------------------------------------------------------
  // Sequencer states and constants
  // ----------------------------------------------------------------
  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_CLEAR = 2'h1;
  localparam [1:0] ST_TRIAL = 2'h2;
  localparam [1:0] ST_DONE  = 2'h3;
  localparam integer RES_MSB = `SAS_RES_MSB;
  localparam [7:0] SETTLE   = TRIAL_CYCLES[7:0];
  localparam [2:0] LSB_IDX  = 3'h0;
  localparam [2:0] MSB_IDX  = RES_MSB[2:0];

  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  reg  [2:0]  bit_q;
  reg  [2:0]  bit_d;
  reg  [7:0]  cnt_q;
  reg  [7:0]  cnt_d;
  reg  [7:0]  res_d;
  reg         en_q;
  reg         en_d;
  reg         done_q;
  reg         done_d;
  reg  [2:0]  sel_d;
  reg         istat_q;
  reg         istat_d;
  reg         ien_q;
  reg         ien_d;
  wire        comp_s;
  wire        wr_fire;
  wire        rd_fire;
  wire        start;
  wire        fin;
  reg  [31:0] rd_word;
  reg         rd_hit;
  reg         wr_hit;

  // The comparator is asynchronous to this clock, so it is synchronised first.
  sas_sync u_comp_sync (
    .clk   (CLOCK),
    .rst_n (RST_N),
    .d     (COMP_HIGH),
    .q     (comp_s)
  );

  // ----------------------------------------------------------------
  // AXI4-Lite handshakes
  // ----------------------------------------------------------------
  // Address and data are taken together; ready is a one-cycle pulse.
  assign wr_fire = AWREADY & AWVALID & WVALID;
  assign rd_fire = ARREADY & ARVALID;

  // Decode of write addresses; unmapped ones answer SLVERR.
  always @* begin
    case (AWADDR)
      `SAS_ADDR_CTRL, `SAS_ADDR_SEL, `SAS_ADDR_ICLR, `SAS_ADDR_IEN: wr_hit = 1'b1;
      `SAS_ADDR_ISTAT: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Read mux; reserved bits read as zero.
  always @* begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (ARADDR)
      `SAS_ADDR_CTRL: begin
        rd_word[`SAS_EN_BIT]             = en_q;
        rd_word[`SAS_DONE_BIT]           = done_q;
        rd_word[`SAS_RES_MSB:0]          = DAC_CODE;
      end
      `SAS_ADDR_SEL:   rd_word[`SAS_SEL_W-1:0] = INPUT_CHANNEL_SELECT;
      `SAS_ADDR_ISTAT: rd_word[`SAS_IRQ_DONE]  = istat_q;
      `SAS_ADDR_ICLR:  rd_word = 32'h0000_0000;
      `SAS_ADDR_IEN:   rd_word[`SAS_IRQ_DONE]  = ien_q;
      default:         rd_hit = 1'b0;
    endcase
  end

  // Bus channel flops. One write and one read are handled at a time.
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      AWREADY <= 1'b0;
      WREADY  <= 1'b0;
      BVALID  <= 1'b0;
      BRESP   <= `SAS_RESP_OKAY;
      ARREADY <= 1'b0;
      RVALID  <= 1'b0;
      RRESP   <= `SAS_RESP_OKAY;
      RDATA   <= 32'h0000_0000;
    end else begin
      AWREADY <= AWVALID & WVALID & ~AWREADY & ~BVALID;
      WREADY  <= AWVALID & WVALID & ~AWREADY & ~BVALID;
      if (wr_fire) begin
        BVALID <= 1'b1;
        BRESP  <= wr_hit ? `SAS_RESP_OKAY : `SAS_RESP_SLVERR;
      end else if (BREADY) begin
        BVALID <= 1'b0;
      end
      ARREADY <= ARVALID & ~ARREADY & ~RVALID;
      if (rd_fire) begin
        RVALID <= 1'b1;
        RDATA  <= rd_word;
        RRESP  <= rd_hit ? `SAS_RESP_OKAY : `SAS_RESP_SLVERR;
      end else if (RREADY) begin
        RVALID <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control word
  // ----------------------------------------------------------------
  // A start is honoured only while idle, so a second write mid-conversion is ignored.
  // ignore busy start
  assign start = wr_fire & (AWADDR == `SAS_ADDR_CTRL) & WSTRB[1] & WDATA[`SAS_EN_BIT]
                 & (state_q == ST_IDLE) & ~en_q;
  assign fin   = (state_q == ST_TRIAL) & (cnt_q == 8'h00) & (bit_q == LSB_IDX);

  // Enable and done flags. Setting beats clearing in the same cycle.
  always @* begin
    en_d   = en_q;
    done_d = done_q;
    if (rd_fire & (ARADDR == `SAS_ADDR_CTRL) & done_q)
      en_d = 1'b0;
    // A start in the same cycle as that read wins, or the sequence would run with the sensor off.
    // start by write
    if (start)
      en_d = 1'b1;
    if (fin)
      en_d = 1'b0;
    if (rd_fire & (ARADDR == `SAS_ADDR_CTRL) & done_q)
      done_d = 1'b0;
    if (fin)
      done_d = 1'b1;
  end

  // Channel select register; zero after reset picks the sensor.
  always @* begin
    sel_d = INPUT_CHANNEL_SELECT;
    if (wr_fire & (AWADDR == `SAS_ADDR_SEL) & WSTRB[0])
      sel_d = WDATA[`SAS_SEL_W-1:0];
  end

  // ----------------------------------------------------------------
  // Successive-approximation sequencer
  // ----------------------------------------------------------------
  // Each trial waits SETTLE cycles so DAC, comparator and synchroniser are stable.
  always @* begin
    state_d = state_q;
    bit_d   = bit_q;
    cnt_d   = cnt_q;
    res_d   = DAC_CODE;
    case (state_q)
      ST_IDLE: begin
        if (start)
          state_d = ST_CLEAR;
      end
      ST_CLEAR: begin
        res_d          = `SAS_RES_RST;
        res_d[MSB_IDX] = 1'b1;
        bit_d          = MSB_IDX;
        cnt_d          = SETTLE;
        state_d        = ST_TRIAL;
      end
      ST_TRIAL: begin
        if (cnt_q != 8'h00) begin
          cnt_d = cnt_q - 8'h01;
        end else begin
          res_d[bit_q] = comp_s;
          if (bit_q == LSB_IDX) begin
            state_d = ST_DONE;
          end else begin
            bit_d        = bit_q - 3'h1;
            res_d[bit_d] = 1'b1;
            cnt_d        = SETTLE;
          end
        end
      end
      ST_DONE: begin
        state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // Interrupt status, clear and enable. The done event wins over a clear.
  always @* begin
    istat_d = istat_q;
    ien_d   = ien_q;
    if (wr_fire & (AWADDR == `SAS_ADDR_ICLR) & WSTRB[0] & WDATA[`SAS_IRQ_DONE])
      istat_d = 1'b0;
    if (fin)
      istat_d = 1'b1;
    if (wr_fire & (AWADDR == `SAS_ADDR_IEN) & WSTRB[0])
      ien_d = WDATA[`SAS_IRQ_DONE];
  end

  // State registers; DAC, select, enable, busy and IRQ outputs come from these flops, bus outputs from the channel flops.
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state_q              <= ST_IDLE;
      bit_q                <= MSB_IDX;
      cnt_q                <= 8'h00;
      en_q                 <= 1'b0;
      done_q               <= 1'b0;
      istat_q              <= 1'b0;
      ien_q                <= 1'b0;
      DAC_CODE             <= `SAS_RES_RST;
      INPUT_CHANNEL_SELECT <= `SAS_SEL_RST;
      SENSOR_ENABLE        <= 1'b0;
      CONV_BUSY            <= 1'b0;
      IRQ                  <= 1'b0;
    end else begin
      state_q              <= state_d;
      bit_q                <= bit_d;
      cnt_q                <= cnt_d;
      en_q                 <= en_d;
      done_q               <= done_d;
      istat_q              <= istat_d;
      ien_q                <= ien_d;
      DAC_CODE             <= res_d;
      INPUT_CHANNEL_SELECT <= sel_d;
      SENSOR_ENABLE        <= en_d;
      CONV_BUSY            <= (state_d == ST_CLEAR) | (state_d == ST_TRIAL);
      IRQ                  <= istat_d & ien_d;
    end
  end
endmodule
`default_nettype wire

// file: common/sas_regs.vh
`ifndef SAS_REGS_VH
`define SAS_REGS_VH
// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define SAS_ADDR_CTRL   32'h800000b0
`define SAS_ADDR_SEL    32'h800000b4
`define SAS_ADDR_ISTAT  32'h800000b8
`define SAS_ADDR_ICLR   32'h800000bc
`define SAS_ADDR_IEN    32'h800000c0
// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define SAS_EN_BIT      9
`define SAS_DONE_BIT    8
`define SAS_RES_MSB     7
`define SAS_RES_W       8
`define SAS_SEL_W       3
`define SAS_RES_RST     8'h00
`define SAS_SEL_RST     3'h0
`define SAS_IRQ_DONE    0
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SAS_CLK_NS      100
`define SAS_SETTLE_NS   800
`define SAS_TRIAL_CYC   ((`SAS_SETTLE_NS + `SAS_CLK_NS - 1) / `SAS_CLK_NS)
// ----------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------
`define SAS_RESP_OKAY   2'h0
`define SAS_RESP_SLVERR 2'h2
`endif

// file: design/sas_sync.v
`timescale 1ns/1ns
`default_nettype none
// Two-stage synchroniser; the first stage feeds only the second.
module sas_sync (
  input  wire clk,
  input  wire rst_n,
  input  wire d,
  output reg  q
);
  reg meta_q;

  // Both stages reset to zero.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
`default_nettype wire

// file: tb/sas_analog_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Converter front end seen by the sequencer
// ----------------------------------------
module sas_analog_model #(
  parameter DELAY_NS = 0
) (
  input  wire logic [7:0]  dac_code,
  input  wire logic [2:0]  channel_sel,
  input  wire logic [63:0] levels,
  output wire logic        comp_high
);
  // select, compare with DAC.
  // Code 0 is the sensor, codes 1 to 7 the external inputs; a delay mimics a slow comparator.
  assign #DELAY_NS comp_high = levels[channel_sel*8 +: 8] > dac_code;
endmodule
`default_nettype wire

// file: tb/sas_top_chk.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Port-level checks of the sequencer
// ----------------------------------------
module sas_chk (
  input wire logic       CLOCK,
  input wire logic       RST_N,
  input wire logic       AWREADY,
  input wire logic       WREADY,
  input wire logic       BVALID,
  input wire logic       ARREADY,
  input wire logic       RVALID,
  input wire logic [7:0] DAC_CODE,
  input wire logic       SENSOR_ENABLE,
  input wire logic       CONV_BUSY
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  // Trial timing assumes the default of eight settle cycles, nine per bit.
  property p_start_clear; $rose(SENSOR_ENABLE) |=> CONV_BUSY && DAC_CODE == 8'h80; endproperty
  a_start_clear: assert property (p_start_clear) else $error("start did not load first trial");
  property p_busy_en; $rose(CONV_BUSY) |-> SENSOR_ENABLE[*8]; endproperty
  a_busy_en: assert property (p_busy_en) else $error("enable dropped early");
  property p_trial_hold;
    $rose(CONV_BUSY) |=> DAC_CODE == 8'h80 ##1 $stable(DAC_CODE)[*8] ##1 DAC_CODE != 8'h80;
  endproperty
  a_trial_hold: assert property (p_trial_hold) else $error("first trial timing wrong");
  property p_conv_len; $rose(CONV_BUSY) |-> ##[60:80] !CONV_BUSY; endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion did not stop");
  property p_end_clear; $fell(CONV_BUSY) |-> ##[0:2] !SENSOR_ENABLE; endproperty
  a_end_clear: assert property (p_end_clear) else $error("enable kept after end");
  property p_wr_pair; AWREADY |-> WREADY && !BVALID; endproperty
  a_wr_pair: assert property (p_wr_pair) else $error("write ready mismatch");
  property p_wr_resp; AWREADY |=> BVALID && !AWREADY; endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
  property p_rd_resp; ARREADY |=> RVALID && !ARREADY; endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
endmodule
bind sas_top sas_chk i_chk (.CLOCK(CLOCK), .RST_N(RST_N), .AWREADY(AWREADY), .WREADY(WREADY), .BVALID(BVALID),
  .ARREADY(ARREADY), .RVALID(RVALID), .DAC_CODE(DAC_CODE), .SENSOR_ENABLE(SENSOR_ENABLE), .CONV_BUSY(CONV_BUSY));
`default_nettype wire

// file: tb/sar_adc_sequencer_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "sas_regs.vh"
// ----------------------------------------
// Sequencer bench
// ----------------------------------------
module sar_adc_sequencer_tb_top;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, lfsr = 32'h3aa822fb, got, ch, res;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, comp_high, sensor_enable, conv_busy, irq;
  logic [1:0]  bresp, rresp, rr;
  logic [31:0] rdata;
  logic [7:0]  dac_code;
  logic [2:0]  channel_sel;
  logic [63:0] levels = 64'h0;
  logic [3:0]  wstrb = 4'hf;
  integer      error_cnt = 0, num_checks = 0, cycles = 0;

  sas_top i_dut (.CLOCK(clock), .RST_N(rst_n), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
    .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
    .RVALID(rvalid), .RREADY(rready), .COMP_HIGH(comp_high), .DAC_CODE(dac_code),
    .INPUT_CHANNEL_SELECT(channel_sel), .SENSOR_ENABLE(sensor_enable), .CONV_BUSY(conv_busy), .IRQ(irq));
  sas_analog_model i_far (.dac_code(dac_code), .channel_sel(channel_sel), .levels(levels), .comp_high(comp_high));

  // Clock, and a ceiling well above eight conversions with polling.
  initial forever #50 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      error_cnt++;
      give_verdict();
    end
  end

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Successive approximation against a comparator that is high when input exceeds the trial.
  function automatic logic [7:0] sar_expect(input logic [7:0] lvl);
    logic [7:0] r;
    r = 8'h00;
    for (int b = 7; b >= 0; b--) begin
      r[b] = 1'b1;
      if (!(lvl > r)) r[b] = 1'b0;
    end
    return r;
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Bus master: requests held until taken, ready held until the answer.
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge clock); while (!(awready && wready));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    while (!bvalid) @(posedge clock);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clock); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge clock);
    rready <= 1'b0;
    got = rdata;
    rr = rresp;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Main sequence: reset values, unmapped place, then one conversion per channel.
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    rd(`SAS_ADDR_CTRL);
    chk(got, 32'h0);
    rd(`SAS_ADDR_SEL);
    chk(got, 32'h0);
    rd(32'h800000c4);
    chk({30'h0, rr}, {30'h0, `SAS_RESP_SLVERR});
    wr(32'h800000c4, 32'h1, `SAS_RESP_SLVERR);
    // A start without the byte lane of the enable bit must not begin a conversion.
    wstrb <= 4'h1;
    wr(`SAS_ADDR_CTRL, 32'h200, `SAS_RESP_OKAY);
    wstrb <= 4'hf;
    rd(`SAS_ADDR_CTRL);
    chk(got, 32'h0);
    $display("test reset done");
    for (ch = 0; ch < 8; ch++) begin
      lfsr = nxt(lfsr);
      levels[ch*8 +: 8] <= (ch == 0) ? 8'h00 : (ch == 7) ? 8'hff : lfsr[7:0];
      wr(`SAS_ADDR_IEN, {31'h0, ch[0]}, `SAS_RESP_OKAY);
      wr(`SAS_ADDR_SEL, ch, `SAS_RESP_OKAY);
      chk({29'h0, channel_sel}, ch);
      wr(`SAS_ADDR_CTRL, 32'h200, `SAS_RESP_OKAY);
      if (ch == 3) wr(`SAS_ADDR_CTRL, 32'h200, `SAS_RESP_OKAY);
      res = {24'h0, sar_expect(levels[ch*8 +: 8])};
      do rd(`SAS_ADDR_CTRL); while (got[8] !== 1'b1 && cycles < 6000);
      chk(got, 32'h100 | res);
      chk({31'h0, irq}, {31'h0, ch[0]});
      rd(`SAS_ADDR_CTRL);
      chk(got, res);
      rd(`SAS_ADDR_ISTAT);
      chk(got, 32'h1);
      wr(`SAS_ADDR_ICLR, 32'h1, `SAS_RESP_OKAY);
      repeat (2) @(posedge clock);
      chk({31'h0, irq}, 32'h0);
      $display("test channel %0d done", ch);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
